/* File: bench/cpu_clock_sequencer_chk.sv */
// Purpose: port assertions for the cpu clock source sequencer
// Assumes: one clk domain, resetn async active low
// Notes: state codes 0=A .. 8=I as reported on cpu_state
`timescale 1ns/100ps
module cpu_clock_sequencer_chk (
  input wire clk,
  input wire resetn,
  input wire rd_en,
  input wire [7:0] rd_data,
  input wire halt_req,
  input wire stop_req,
  input wire power_on_detect_level_opt,
  input wire cpu_clk_en,
  input wire [1:0] cpu_src,
  input wire [3:0] cpu_state,
  input wire high_freq_gain
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_leave_reset: assert property (
    cpu_state == 4'h0 && !power_on_detect_level_opt |-> ##[1:8] cpu_state == 4'h1)
    else $error("reset state held too long");
  // a switch in progress holds cpu_clk_en low, so requests are only judged when it runs
  a_halt_match: assert property (
    cpu_clk_en && halt_req && !stop_req && cpu_state inside {4'h1, 4'h2, 4'h3}
    |=> cpu_state == $past(cpu_state) + 4'h3) else $error("wrong halt state");
  a_stop_match: assert property (
    cpu_clk_en && stop_req && !halt_req && cpu_state inside {4'h1, 4'h2}
    |=> cpu_state == $past(cpu_state) + 4'h6) else $error("wrong stop state");
  a_no_stop_sub: assert property (
    cpu_clk_en && stop_req && !halt_req && cpu_state == 4'h3 |=> cpu_state == 4'h3)
    else $error("stop taken on subsystem clock");
  a_src_state: assert property (
    cpu_state inside {4'h1, 4'h2, 4'h3} |-> cpu_src == cpu_state[1:0] - 2'h1)
    else $error("source code disagrees with state");
  a_standby_gated: assert property (
    cpu_state == 4'h0 || cpu_state > 4'h3 |-> !cpu_clk_en)
    else $error("cpu clock runs in reset or standby");
  a_rd_idle: assert property (
    !rd_en |=> rd_data == 8'h00) else $error("read data outside read cycle");
  a_safe_switch: assert property (
    $changed(cpu_src) |-> $past(cpu_clk_en) == 1'b0)
    else $error("source changed while cpu clock ran");
  a_gain_hold: assert property (
    $rose(high_freq_gain) |=> ##1 (!cpu_clk_en) [*8])
    else $error("cpu clock not withheld after gain");

  c_halt_hs: cover property (cpu_state == 4'h5);
  c_on_sub: cover property (cpu_state == 4'h3);
  c_stop_int: cover property (cpu_state == 4'h7);
endmodule // cpu_clock_sequencer_chk

bind cpu_clock_source_sequencer cpu_clock_sequencer_chk chk (
  .clk, .resetn, .rd_en, .rd_data, .halt_req, .stop_req, .power_on_detect_level_opt,
  .cpu_clk_en, .cpu_src, .cpu_state, .high_freq_gain
);

/* File: bench/cpu_clock_source_sequencer_bench.sv */
// Purpose: directed bench for the cpu clock source sequencer
// Assumes: default parameters, read data one cycle after rd_en
// Notes: each task drives one scenario and judges it before returning
`timescale 1ns/100ps
`include "cpu_clk_map.vh"
module cpu_clock_source_sequencer_bench;
  reg clk;
  reg resetn;
  reg [2:0] addr;
  reg [7:0] wr_data;
  reg wr_en;
  reg rd_en;
  reg halt_req;
  reg stop_req;
  reg wake_pin;
  reg power_ok_pin;
  reg power_on_detect_level_opt;
  wire [7:0] rd_data;
  wire cpu_clk_en;
  wire [1:0] cpu_src;
  wire [3:0] cpu_state;
  wire high_freq_gain;
  wire int_osc_en;
  wire main_osc_en;
  wire sub_osc_en;
  integer errors;
  integer tests_run;
  integer n;

  cpu_clock_source_sequencer dut (
    .clk, .resetn, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .halt_req, .stop_req,
    .wake_pin, .power_ok_pin, .power_on_detect_level_opt, .cpu_clk_en, .cpu_src,
    .cpu_state, .int_osc_en, .main_osc_en, .sub_osc_en, .high_freq_gain
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task chk(input [15:0] seen, input [15:0] want);
  begin
    tests_run = tests_run + 1;
    if (seen !== want)
    begin
      errors = errors + 1;
      $display("BAD t=%0t got %h want %h", $time, seen, want);
    end
  end
  endtask

  task print_verdict;
  begin
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask

  task wr(input [2:0] a, input [7:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  end
  endtask

  task rd(input [2:0] a, input [7:0] e);
  begin
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk({8'h00, rd_data}, {8'h00, e});
  end
  endtask

  // n is left holding the cycles spent, so callers can judge hold times
  task wait_run(input [3:0] s);
  begin
    n = 0;
    #1;
    while (!(cpu_state === s && cpu_clk_en === 1'b1) && n < 6000)
    begin
      @(posedge clk);
      #1 n = n + 1;
    end
    if (n >= 6000)
    begin
      errors = errors + 1;
      $display("BAD t=%0t no run in state %0d", $time, s);
      print_verdict;
    end
  end
  endtask

  task instr(input is_stop, input [3:0] want, input [3:0] back);
  begin
    @(posedge clk);
    halt_req <= !is_stop;
    stop_req <= is_stop;
    @(posedge clk);
    halt_req <= 1'b0;
    stop_req <= 1'b0;
    #1 chk(cpu_state, want);
    chk(int_osc_en, want < 4'h7);
    @(posedge clk);
    wake_pin <= 1'b1;
    repeat (6) @(posedge clk);
    wake_pin <= 1'b0;
    wait_run(back);
  end
  endtask

  task do_reset(input strap);
  begin
    @(posedge clk);
    resetn <= 1'b0;
    power_on_detect_level_opt <= strap;
    power_ok_pin <= !strap;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
  end
  endtask

  task t_power_on;
  begin
    repeat (50) @(posedge clk);
    #1 chk(cpu_state, 4'h0);
    @(posedge clk);
    power_ok_pin <= 1'b1;
    wait_run(4'h1);
    chk(n >= 4000 && n < 4100, 1'b1);
    $display("power_on done");
  end
  endtask

  task t_defaults;
  begin
    wait_run(4'h1);
    chk(int_osc_en, 1'b1);
    chk(main_osc_en, 1'b0);
    chk(sub_osc_en, 1'b0);
    chk(cpu_src, `SRC_INT);
    repeat (20) @(posedge clk);
    rd(`OFF_OSC_PIN_MODE, `RST_OSC_PIN_MODE);
    rd(`OFF_MAIN_OSC_CTRL, 8'h80);
    rd(`OFF_MAIN_CLK_MODE, 8'h00);
    rd(`OFF_PROC_CLK_CTRL, 8'h00);
    rd(`OFF_INT_OSC_MODE, 8'h80);
    rd(`OFF_CPU_STATE, 8'h01);
    rd(3'h7, 8'h00);
    $display("defaults done");
  end
  endtask

  task t_sub;
  begin
    wr(`OFF_OSC_PIN_MODE, 8'h30);
    wr(`OFF_PROC_CLK_CTRL, 8'h10);
    wait_run(4'h3);
    chk(sub_osc_en, 1'b1);
    chk(cpu_src, `SRC_SUB);
    rd(`OFF_PROC_CLK_CTRL, 8'h30);
    instr(1'b0, 4'h6, 4'h3);
    instr(1'b1, 4'h3, 4'h3);
    wr(`OFF_INT_OSC_MODE, 8'h00);
    rd(`OFF_INT_OSC_MODE, 8'h80);
    wr(`OFF_PROC_CLK_CTRL, 8'h00);
    wait_run(4'h1);
    chk(cpu_src, `SRC_INT);
    $display("sub done");
  end
  endtask

  task t_hs;
  begin
    wr(`OFF_OSC_PIN_MODE, 8'hC0);
    wr(`OFF_MAIN_OSC_CTRL, 8'h00);
    wr(`OFF_MAIN_CLK_MODE, 8'h01);
    rd(`OFF_MAIN_CLK_MODE, 8'h00);
    wr(`OFF_MAIN_CLK_MODE, 8'h04);
    wr(`OFF_MAIN_CLK_MODE, 8'h05);
    wait_run(4'h2);
    chk(main_osc_en, 1'b1);
    chk(cpu_src, `SRC_HS);
    rd(`OFF_MAIN_CLK_MODE, 8'h07);
    wr(`OFF_MAIN_CLK_MODE, 8'h01);
    rd(`OFF_MAIN_CLK_MODE, 8'h07);
    instr(1'b0, 4'h5, 4'h2);
    instr(1'b1, 4'h8, 4'h2);
    wr(`OFF_MAIN_CLK_MODE, 8'h04);
    wait_run(4'h1);
    instr(1'b0, 4'h4, 4'h1);
    instr(1'b1, 4'h7, 4'h1);
    $display("hs done");
  end
  endtask

  task t_gain;
  begin
    wr(`OFF_MAIN_CLK_MODE, 8'h05);
    wait_run(4'h2);
    wr(`OFF_OSC_PIN_MODE, 8'hC1);
    repeat (2) @(posedge clk);
    wait_run(4'h2);
    chk(n >= 990, 1'b1);
    chk(high_freq_gain, 1'b1);
    wr(`OFF_OSC_PIN_MODE, 8'hC0);
    rd(`OFF_OSC_PIN_MODE, 8'hC1);
    chk(high_freq_gain, 1'b1);
    $display("gain done");
  end
  endtask

  // fast-start sub start, then crystal main with a counted stabilization read
  task t_xtal;
  begin
    wr(`OFF_PROC_CLK_CTRL, 8'h40);
    repeat (20) @(posedge clk);
    wr(`OFF_PROC_CLK_CTRL, 8'h50);
    wait_run(4'h3);
    chk(sub_osc_en, 1'b1);
    wr(`OFF_OSC_PIN_MODE, 8'h41);
    repeat (40) @(posedge clk);
    rd(`OFF_OSC_STAB, 8'h02);
    wr(`OFF_PROC_CLK_CTRL, 8'h40);
    wait_run(4'h2);
    chk(cpu_src, `SRC_HS);
    chk(main_osc_en, 1'b1);
    $display("xtal done");
  end
  endtask

  initial
  begin
    errors = 0;
    tests_run = 0;
    addr = 3'h0;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    halt_req = 1'b0;
    stop_req = 1'b0;
    wake_pin = 1'b0;
    resetn = 1'b0;
    power_ok_pin = 1'b0;
    power_on_detect_level_opt = 1'b1;
    do_reset(1'b1);
    t_power_on;
    do_reset(1'b0);
    t_defaults;
    t_sub;
    t_hs;
    t_gain;
    t_xtal;
    print_verdict;
  end
endmodule // cpu_clock_source_sequencer_bench

/* File: include/cpu_clk_map.vh */
// Purpose: offsets, field positions, reset values and timing for the cpu clock sequencer
// Assumes: 8-bit registers on a plain strobe port, 200 MHz clock
// Notes: definitions only
`ifndef CPU_CLK_MAP_VH
`define CPU_CLK_MAP_VH

// register offsets
`define OFF_OSC_PIN_MODE 3'h0
`define OFF_MAIN_OSC_CTRL 3'h1
`define OFF_MAIN_CLK_MODE 3'h2
`define OFF_PROC_CLK_CTRL 3'h3
`define OFF_INT_OSC_MODE 3'h4
`define OFF_OSC_STAB 3'h5
`define OFF_CPU_STATE 3'h6

// osc_pin_mode_reg fields
`define B_MAIN_EXT_SEL 7
`define B_MAIN_PIN_OSC 6
`define B_SUB_EXT_SEL 5
`define B_SUB_PIN_OSC 4
`define B_HF_GAIN 0
// main_osc_ctrl_reg
`define B_MAIN_OSC_HALT 7
// main_clock_mode_reg
`define B_HS_ALLOW 2
`define B_MAIN_SRC_STAT 1
`define B_MAIN_SRC_SEL 0
// processor_clock_ctrl_reg
`define B_SUB_FAST_START 6
`define B_CPU_ON_SUB 5
`define B_CPU_SUB_SEL 4
// int_osc_mode_reg
`define B_INT_OSC_STABLE 7
`define B_INT_OSC_HALT 0

// reset values
`define RST_OSC_PIN_MODE 8'h00
`define RST_MAIN_OSC_HALT 1'b1
`define RST_INT_OSC_HALT 1'b0

// timing
`define CLK_PERIOD_PS 5000
`define RESET_PROC_PS 20000000
`define GAIN_HOLD_PS 5000000

// cpu source codes, as reported: 00 internal, 01 high-speed, 1x subsystem
`define SRC_INT 2'h0
`define SRC_HS 2'h1
`define SRC_SUB 2'h2

`endif

/* File: rtl/cpu_clock_source_sequencer.v */
// Purpose: cpu clock source selection and standby sequencing
// Assumes: halt_req/stop_req are one-cycle pulses on clk; wake and pins are async
// Notes: the cpu clock itself is gated by cpu_clk_en; source mux lives outside
`timescale 1ns/100ps
`include "cpu_clk_map.vh"
module cpu_clock_source_sequencer #(
  parameter SW_CYC = 4,
  parameter INT_SETTLE_CYC = 16,
  parameter STAB_SHIFT = 4
) (
  input wire clk,
  input wire resetn,
  input wire [2:0] addr,
  input wire [7:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rd_data,
  input wire halt_req,
  input wire stop_req,
  input wire wake_pin,
  input wire power_ok_pin,
  input wire power_on_detect_level_opt,
  output reg cpu_clk_en,
  output reg [1:0] cpu_src,
  output reg [3:0] cpu_state,
  output reg int_osc_en,
  output reg main_osc_en,
  output reg sub_osc_en,
  output reg high_freq_gain
);
  localparam [3:0] ST_A = 4'h0;
  localparam [3:0] ST_B = 4'h1;
  localparam [3:0] ST_C = 4'h2;
  localparam [3:0] ST_D = 4'h3;
  localparam [3:0] ST_E = 4'h4;
  localparam [3:0] ST_F = 4'h5;
  localparam [3:0] ST_G = 4'h6;
  localparam [3:0] ST_H = 4'h7;
  localparam [3:0] ST_I = 4'h8;

  // least times round up to whole cycles
  localparam integer RPROC_INT = (`RESET_PROC_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
  localparam [11:0] RPROC_CYC = RPROC_INT[11:0];
  localparam integer GAIN_INT = (`GAIN_HOLD_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
  localparam [11:0] GAIN_CYC = GAIN_INT[11:0];
  localparam [11:0] STRAP_CYC = 12'h006;
  localparam [11:0] SW_CYC_W = SW_CYC[11:0];
  localparam [7:0] INT_SETTLE_W = INT_SETTLE_CYC[7:0];

  // synchronised pins: wake, power good, strap
  wire [2:0] pins_s;
  pin_sync3 #(
    .W(3)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .pin({power_on_detect_level_opt, power_ok_pin, wake_pin}),
    .level_q(pins_s)
  );
  wire wake_s = pins_s[0];
  wire power_ok_s = pins_s[1];

  // software fields
  reg main_ext_input_sel_q;
  reg main_pin_osc_mode_q;
  reg sub_ext_input_sel_q;
  reg sub_pin_osc_mode_q;
  reg high_freq_gain_q;
  reg main_osc_halt_q;
  reg hs_source_allow_q;
  reg main_source_select_q;
  reg sub_fast_start_q;
  reg cpu_subsystem_select_q;
  reg int_osc_halt_q;
  reg gain_locked_q;
  reg allow_locked_q;

  // device state
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [1:0] src_q;
  reg [1:0] src_d;
  reg [11:0] cnt_q;
  reg [11:0] cnt_d;
  reg [11:0] gain_hold_q;
  reg strap_q;
  reg [7:0] int_settle_q;
  reg int_osc_stable_flag_q;
  reg [15:0] stab_q;
  reg wake_seen_q;

  function [1:0] want_src;
    input sub_sel;
    input main_sel;
    begin
      if (sub_sel)
        want_src = `SRC_SUB;
      else if (main_sel)
        want_src = `SRC_HS;
      else
        want_src = `SRC_INT;
    end
  endfunction

  function [3:0] run_state;
    input [1:0] src;
    begin
      case (src)
        `SRC_INT: run_state = ST_B;
        `SRC_HS: run_state = ST_C;
        default: run_state = ST_D;
      endcase
    end
  endfunction

  function is_run;
    input [3:0] st;
    begin
      is_run = (st == ST_B) || (st == ST_C) || (st == ST_D);
    end
  endfunction

  wire wr_pin = wr_en && (addr == `OFF_OSC_PIN_MODE);
  wire wr_moc = wr_en && (addr == `OFF_MAIN_OSC_CTRL);
  wire wr_mcm = wr_en && (addr == `OFF_MAIN_CLK_MODE);
  wire wr_pcc = wr_en && (addr == `OFF_PROC_CLK_CTRL);
  wire wr_rcm = wr_en && (addr == `OFF_INT_OSC_MODE);
  wire [1:0] want = want_src(cpu_subsystem_select_q, main_source_select_q);
  wire stopped = (state_q == ST_H) || (state_q == ST_I);
  wire wake_rise = wake_s && !wake_seen_q;

  // register writes
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      main_ext_input_sel_q <= 1'b0;
      main_pin_osc_mode_q <= 1'b0;
      sub_ext_input_sel_q <= 1'b0;
      sub_pin_osc_mode_q <= 1'b0;
      high_freq_gain_q <= 1'b0;
      main_osc_halt_q <= `RST_MAIN_OSC_HALT;
      hs_source_allow_q <= 1'b0;
      main_source_select_q <= 1'b0;
      sub_fast_start_q <= 1'b0;
      cpu_subsystem_select_q <= 1'b0;
      int_osc_halt_q <= `RST_INT_OSC_HALT;
      gain_locked_q <= 1'b0;
      allow_locked_q <= 1'b0;
    end
    else
    begin
      if (wr_pin)
      begin
        main_ext_input_sel_q <= wr_data[`B_MAIN_EXT_SEL];
        main_pin_osc_mode_q <= wr_data[`B_MAIN_PIN_OSC];
        sub_ext_input_sel_q <= wr_data[`B_SUB_EXT_SEL];
        sub_pin_osc_mode_q <= wr_data[`B_SUB_PIN_OSC];
        // one change only; a write of the same value does not use it up
        if (!gain_locked_q && wr_data[`B_HF_GAIN] != high_freq_gain_q)
        begin
          high_freq_gain_q <= wr_data[`B_HF_GAIN];
          gain_locked_q <= 1'b1;
        end
      end
      if (wr_moc)
        main_osc_halt_q <= wr_data[`B_MAIN_OSC_HALT];
      if (wr_mcm)
      begin
        if (!allow_locked_q && wr_data[`B_HS_ALLOW] != hs_source_allow_q)
        begin
          hs_source_allow_q <= wr_data[`B_HS_ALLOW];
          allow_locked_q <= 1'b1;
        end
        // select sticks at 0 until the high-speed source is allowed
        if (hs_source_allow_q || wr_data[`B_HS_ALLOW])
          main_source_select_q <= wr_data[`B_MAIN_SRC_SEL];
      end
      if (wr_pcc)
      begin
        sub_fast_start_q <= wr_data[`B_SUB_FAST_START];
        cpu_subsystem_select_q <= wr_data[`B_CPU_SUB_SEL];
      end
      if (wr_rcm)
        int_osc_halt_q <= wr_data[`B_INT_OSC_HALT];
    end
  end

  // state sequencing
  always @*
  begin
    state_d = state_q;
    src_d = src_q;
    cnt_d = (cnt_q != 12'h000) ? cnt_q - 12'h001 : 12'h000;
    case (state_q)
      ST_A:
      begin
        // strap settles through the synchroniser before it is trusted
        if (cnt_q == 12'h000)
        begin
          if (!strap_q)
            state_d = ST_B;
          else if (power_ok_s)
          begin
            state_d = ST_B;
            cnt_d = RPROC_CYC;
          end
        end
      end
      ST_B, ST_C, ST_D:
      begin
        if (cnt_q == 12'h000 && want != src_q)
          cnt_d = SW_CYC_W;
        else if (cnt_q == 12'h001 && want != src_q)
        begin
          src_d = want;
          state_d = run_state(want);
        end
        else if (cnt_q == 12'h000 && halt_req)
        begin
          case (state_q)
            ST_B: state_d = ST_E;
            ST_C: state_d = ST_F;
            default: state_d = ST_G;
          endcase
        end
        else if (cnt_q == 12'h000 && stop_req && state_q != ST_D)
          state_d = (state_q == ST_B) ? ST_H : ST_I;
      end
      ST_E, ST_F, ST_G, ST_H, ST_I:
      begin
        if (wake_rise)
          state_d = run_state(src_q);
      end
      default:
        state_d = ST_B;
    endcase
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_A;
      src_q <= `SRC_INT;
      cnt_q <= STRAP_CYC;
      strap_q <= 1'b0;
      wake_seen_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      src_q <= src_d;
      cnt_q <= cnt_d;
      wake_seen_q <= wake_s;
      // strap caught only while still in the reset state
      if (state_q == ST_A)
        strap_q <= pins_s[2];
    end
  end

  // clock withhold after the gain bit goes high
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      gain_hold_q <= 12'h000;
    else if (wr_pin && !gain_locked_q && wr_data[`B_HF_GAIN] && !high_freq_gain_q)
      gain_hold_q <= GAIN_CYC;
    else if (gain_hold_q != 12'h000)
      gain_hold_q <= gain_hold_q - 12'h001;
  end

  // internal oscillator settle and main oscillator stabilization count
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      int_settle_q <= 8'h00;
      int_osc_stable_flag_q <= 1'b0;
      stab_q <= 16'h0000;
    end
    else
    begin
      if (int_osc_halt_q || stopped)
      begin
        int_settle_q <= 8'h00;
        int_osc_stable_flag_q <= 1'b0;
      end
      else if (int_settle_q != INT_SETTLE_W)
        int_settle_q <= int_settle_q + 8'h01;
      else
        int_osc_stable_flag_q <= 1'b1;
      // only a running crystal counts; external input has nothing to wait for
      if (main_osc_halt_q || !main_pin_osc_mode_q || main_ext_input_sel_q || stopped)
        stab_q <= 16'h0000;
      else if (stab_q != 16'hFFFF)
        stab_q <= stab_q + 16'h0001;
    end
  end

  // read port, data in the cycle after the strobe
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rd_data <= 8'h00;
    else if (rd_en)
    begin
      case (addr)
        `OFF_OSC_PIN_MODE:
          rd_data <= {main_ext_input_sel_q, main_pin_osc_mode_q, sub_ext_input_sel_q,
            sub_pin_osc_mode_q, 3'h0, high_freq_gain_q};
        `OFF_MAIN_OSC_CTRL:
          rd_data <= {main_osc_halt_q, 7'h00};
        `OFF_MAIN_CLK_MODE:
          rd_data <= {5'h00, hs_source_allow_q, src_q == `SRC_HS,
            main_source_select_q};
        `OFF_PROC_CLK_CTRL:
          rd_data <= {1'b0, sub_fast_start_q, src_q[1], cpu_subsystem_select_q,
            4'h0};
        `OFF_INT_OSC_MODE:
          rd_data <= {int_osc_stable_flag_q, 6'h00, int_osc_halt_q};
        `OFF_OSC_STAB:
          rd_data <= stab_q[STAB_SHIFT+7 -: 8];
        `OFF_CPU_STATE:
          rd_data <= {4'h0, state_q};
        default:
          rd_data <= 8'h00;
      endcase
    end
    else
      rd_data <= 8'h00;
  end

  // registered outputs
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cpu_clk_en <= 1'b0;
      cpu_src <= `SRC_INT;
      cpu_state <= ST_A;
      int_osc_en <= 1'b0;
      main_osc_en <= 1'b0;
      sub_osc_en <= 1'b0;
      high_freq_gain <= 1'b0;
    end
    else
    begin
      // clock gated across a switch so no short pulse reaches the cpu
      cpu_clk_en <= is_run(state_d) && (cnt_d == 12'h000) &&
        (gain_hold_q == 12'h000);
      cpu_src <= src_d;
      cpu_state <= state_d;
      // stop halts internal and main oscillators; subsystem keeps running
      int_osc_en <= !int_osc_halt_q && !(state_d == ST_H || state_d == ST_I);
      main_osc_en <= main_pin_osc_mode_q && !main_osc_halt_q &&
        !(state_d == ST_H || state_d == ST_I);
      sub_osc_en <= sub_fast_start_q || sub_pin_osc_mode_q;
      high_freq_gain <= high_freq_gain_q;
    end
  end
endmodule // cpu_clock_source_sequencer

/* File: rtl/pin_sync3.v */
// Purpose: three-stage synchroniser for pin inputs with an agreement filter
// Assumes: inputs are asynchronous to clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/100ps
module pin_sync3 #(
  parameter W = 1
) (
  input wire clk,
  input wire resetn,
  input wire [W-1:0] pin,
  output reg [W-1:0] level_q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  integer i;

  // stage one feeds only stage two, never any decision logic
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      level_q <= {W{1'b0}};
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < W; i = i + 1)
      begin
        if (s2_q[i] == s3_q[i])
          level_q[i] <= s3_q[i];
      end
    end
  end
endmodule // pin_sync3
